// ==== include/hss_pkg.sv ====
/*
 * hall sample sequencer package: timing constants, phase codes, output codes.
 * assumes a single system clock of 10 MHz driving all sequencer logic.
 */
package hss_pkg;

	// =====================================================================
	// clock and internal tick
	// =====================================================================
	localparam int unsigned CLOCK_HZ        = 10000000;
	localparam int unsigned TICK_PERIOD_NS  = 10000;
	localparam int unsigned TICK_CYCLES     = TICK_PERIOD_NS / (1000000000 / CLOCK_HZ);

	// =====================================================================
	// conversion sequence in internal ticks
	// =====================================================================
	localparam int unsigned TRIG_TICKS      = 1;
	localparam int unsigned AWAKE_TICKS     = 12;
	localparam int unsigned UPDATE_TICKS    = 1;
	localparam int unsigned EXT_CONV_TICKS  = 14;
	localparam int unsigned TURBO_CONV_TICKS = 16;

	// =====================================================================
	// micropower rate
	// =====================================================================
	localparam int unsigned MICRO_RATE_HZ   = 24;
	localparam int unsigned MICRO_PERIOD_CYCLES = CLOCK_HZ / MICRO_RATE_HZ;
	localparam int unsigned MIN_PULSE_NS    = 20000;

	// =====================================================================
	// output codes
	// =====================================================================
	localparam int unsigned CODE_WIDTH      = 8;
	localparam logic [7:0]  CODE_MID        = 8'h80;
	localparam logic [7:0]  CODE_RESET      = 8'h80;

	// =====================================================================
	// sequencer phases
	// =====================================================================
	typedef enum logic [1:0] {
		PH_SLEEP  = 2'b00,
		PH_TRIG   = 2'b01,
		PH_AWAKE  = 2'b10,
		PH_UPDATE = 2'b11
	} hss_phase_e;

endpackage : hss_pkg

// ==== rtl/hss_quantizer.sv ====
/*
 * signed field sample to 8-bit offset-binary output code.
 * assumes the field input is a signed two's complement value, positive = south.
 */
module hss_quantizer #(
	parameter int unsigned FIELD_WIDTH = 12
) (
	// field sample
	input  wire logic signed [FIELD_WIDTH-1:0] field,
	// output code
	output logic         [7:0]             code
);

	// =====================================================================
	// quantization
	// =====================================================================
	logic signed [7:0] top_bits;

	always_comb begin
		// zero field sits on the 127/128 boundary: +0 gives mid-scale
		top_bits = field[FIELD_WIDTH-1 -: 8];
		// offset binary: south above mid-scale, north below, full 0..255
		code     = {~top_bits[7], top_bits[6:0]};
	end

endmodule : hss_quantizer

// ==== rtl/hss_sequencer.sv ====
/*
 * sampling sequencer: mode pin decode, conversion phase timing, output latch.
 * assumes the mode pin and field sample are synchronous to CLOCK (10 MHz).
 */
// Contract
// - pin low continuously gives micropower sampling at 24 Hz.
// - pin weakly pulled low, floating selects micropower.
// - pin high continuously gives turbo sampling at 6.25 kHz.
// - turbo conversion period is 16 ticks, 160 us.
// - each external pulse starts one sample, 24 Hz to 7.14 kHz; the code accepts a new start at most every 15 ticks (150 us).
// - external conversion completes within 14 ticks, 140 us.
// - one tick trigger delay after pin rises before acquiring; the code first waits for the next tick after the rise, so 1 to 2 ticks.
// - awake acquisition phase lasts 12 ticks after the trigger delay.
// - final tick loads new result into output, then sleep.
// - zero field is the code boundary; slightly positive gives mid-scale.
// - 8-bit converter and output, codes 0 through 255.
// - south field raises code, north lowers it, symmetric about null.
module hss_sequencer #(
	parameter int unsigned FIELD_WIDTH  = 12,
	parameter int unsigned MICRO_CYCLES = hss_pkg::MICRO_PERIOD_CYCLES
) (
	// clock and reset
	input  wire logic                          CLOCK,
	input  wire logic                          RESET,
	// mode select pin
	input  wire logic                          MODE_SELECT_PIN,
	output logic                               MODE_SELECT_PULL_DOWN,
	// field sample from the sensing front end
	input  wire logic signed [FIELD_WIDTH-1:0] FIELD_SAMPLE,
	// status and output
	output logic                               AWAKE,
	output logic                               TURBO_MODE,
	output logic                               SAMPLE_DONE,
	output logic             [7:0]             OUTPUT_CODE
);

	// =====================================================================
	// tick generator
	// =====================================================================
	localparam int unsigned TW = $clog2(hss_pkg::TICK_CYCLES);
	localparam logic [TW-1:0] TICK_LAST = TW'(hss_pkg::TICK_CYCLES - 1);
	localparam int unsigned MW = $clog2(MICRO_CYCLES);
	localparam logic [MW-1:0] MICRO_LAST = MW'(MICRO_CYCLES - 1);

	logic [TW-1:0] tick_cnt_q;
	logic          tick;

	// weak pull-down always on
	assign MODE_SELECT_PULL_DOWN = 1'b1;

	assign tick = (tick_cnt_q == TICK_LAST);

	always_ff @(posedge CLOCK) begin
		if (RESET || tick) begin
			tick_cnt_q <= '0;
		end else begin
			tick_cnt_q <= tick_cnt_q + 1'b1;
		end
	end

	// =====================================================================
	// mode pin capture
	// =====================================================================
	logic pin_q;
	logic pin_prev_q;
	logic pin_rise;

	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			pin_q      <= 1'b0;
			pin_prev_q <= 1'b0;
		end else begin
			pin_q      <= MODE_SELECT_PIN;
			pin_prev_q <= pin_q;
		end
	end

	assign pin_rise = pin_q && !pin_prev_q;

	// pending external trigger, held until the sequencer can accept it
	logic trig_pend_q;
	logic start;
	hss_pkg::hss_phase_e phase_q;
	logic [3:0] ph_ticks_q;
	logic [3:0] conv_ticks_q;
	logic [MW-1:0] micro_cnt_q;
	logic          micro_due;
	logic          micro_pend_q;

	// =====================================================================
	// micropower period
	// =====================================================================
	assign micro_due = (micro_cnt_q == MICRO_LAST);

	always_ff @(posedge CLOCK) begin
		if (RESET || pin_q || micro_due) begin
			micro_cnt_q <= '0;
		end else begin
			micro_cnt_q <= micro_cnt_q + 1'b1;
		end
	end

	// a period end that misses the tick waits here for the next tick
	always_ff @(posedge CLOCK) begin
		if (RESET || pin_q) begin
			micro_pend_q <= 1'b0;
		end else if (micro_due && !start) begin
			micro_pend_q <= 1'b1;
		end else if (start) begin
			micro_pend_q <= 1'b0;
		end
	end

	// =====================================================================
	// sample start
	// =====================================================================
	localparam logic [3:0] TRIG_T   = 4'(hss_pkg::TRIG_TICKS);
	localparam logic [3:0] AWAKE_T  = 4'(hss_pkg::AWAKE_TICKS);
	localparam logic [3:0] UPD_T    = 4'(hss_pkg::UPDATE_TICKS);
	localparam logic [3:0] TURBO_T  = 4'(hss_pkg::TURBO_CONV_TICKS - 1);

	logic idle;
	logic turbo_due;

	assign idle      = (phase_q == hss_pkg::PH_SLEEP);
	// turbo: pin still high once the 16-tick period closes
	assign turbo_due = idle && pin_q && !pin_rise && !trig_pend_q && tick &&
	                   (conv_ticks_q >= TURBO_T);
	assign start     = idle && tick && (trig_pend_q || turbo_due ||
	                   (!pin_q && (micro_due || micro_pend_q)));

	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			trig_pend_q <= 1'b0;
		end else if (pin_rise) begin
			trig_pend_q <= 1'b1;
		end else if (start) begin
			trig_pend_q <= 1'b0;
		end
	end

	// =====================================================================
	// phase sequencer
	// =====================================================================
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			phase_q    <= hss_pkg::PH_SLEEP;
			ph_ticks_q <= 4'h0;
		end else if (tick) begin
			case (phase_q)
				hss_pkg::PH_SLEEP: begin
					if (start) begin
						phase_q    <= hss_pkg::PH_TRIG;
						ph_ticks_q <= 4'h1;
					end
				end
				hss_pkg::PH_TRIG: begin
					if (ph_ticks_q >= TRIG_T) begin
						phase_q    <= hss_pkg::PH_AWAKE;
						ph_ticks_q <= 4'h1;
					end else begin
						ph_ticks_q <= ph_ticks_q + 4'h1;
					end
				end
				hss_pkg::PH_AWAKE: begin
					if (ph_ticks_q >= AWAKE_T) begin
						phase_q    <= hss_pkg::PH_UPDATE;
						ph_ticks_q <= 4'h1;
					end else begin
						ph_ticks_q <= ph_ticks_q + 4'h1;
					end
				end
				default: begin
					if (ph_ticks_q >= UPD_T) begin
						phase_q    <= hss_pkg::PH_SLEEP;
						ph_ticks_q <= 4'h0;
					end else begin
						ph_ticks_q <= ph_ticks_q + 4'h1;
					end
				end
			endcase
		end
	end

	// ticks since the last start less one, saturating; spaces turbo samples
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			conv_ticks_q <= 4'h0;
		end else if (tick) begin
			if (start) begin
				conv_ticks_q <= 4'h0;
			end else if (conv_ticks_q != 4'hF) begin
				conv_ticks_q <= conv_ticks_q + 4'h1;
			end
		end
	end

	// =====================================================================
	// conversion and output stage
	// =====================================================================
	logic [7:0] conv_code;
	logic [7:0] acq_q;
	logic       upd_edge;

	hss_quantizer #(
		.FIELD_WIDTH(FIELD_WIDTH)
	) u_quant (
		.field(FIELD_SAMPLE),
		.code (conv_code)
	);

	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			acq_q <= hss_pkg::CODE_RESET;
		end else if (phase_q == hss_pkg::PH_AWAKE) begin
			acq_q <= conv_code;
		end
	end

	// last tick of the update phase ends the conversion (14 ticks total)
	assign upd_edge = tick && (phase_q == hss_pkg::PH_UPDATE) && (ph_ticks_q >= UPD_T);

	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			OUTPUT_CODE <= hss_pkg::CODE_RESET;
			SAMPLE_DONE <= 1'b0;
		end else begin
			SAMPLE_DONE <= upd_edge;
			if (upd_edge) begin
				OUTPUT_CODE <= acq_q;
			end
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			AWAKE      <= 1'b0;
			TURBO_MODE <= 1'b0;
		end else begin
			AWAKE      <= (phase_q == hss_pkg::PH_AWAKE);
			TURBO_MODE <= turbo_due ? 1'b1 : (!pin_q ? 1'b0 : TURBO_MODE);
		end
	end

	// =====================================================================
	// assertions
	// =====================================================================
	// cycles since the last sample start, saturating; timing checks only
	localparam logic [10:0] CHK_TRIG  = 11'(hss_pkg::TICK_CYCLES * hss_pkg::TRIG_TICKS);
	localparam logic [10:0] CHK_CONV  = 11'(hss_pkg::TICK_CYCLES * hss_pkg::EXT_CONV_TICKS - 1);
	localparam logic [10:0] CHK_TURBO = 11'(hss_pkg::TICK_CYCLES * hss_pkg::TURBO_CONV_TICKS - 1);
	logic [10:0] chk_cyc_q;

	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			chk_cyc_q <= 11'h7FF;
		end else if (start) begin
			chk_cyc_q <= 11'h000;
		end else if (chk_cyc_q != 11'h7FF) begin
			chk_cyc_q <= chk_cyc_q + 11'h001;
		end
	end

	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RESET);

	a_output_held: assert property (!upd_edge |=> $stable(OUTPUT_CODE))
		else $error("output changed outside update");
	a_trig_one_tick: assert property (
		$rose(phase_q == hss_pkg::PH_AWAKE) |-> (chk_cyc_q == CHK_TRIG))
		else $error("trigger delay not one tick");
	a_awake_len: assert property (
		$rose(phase_q == hss_pkg::PH_AWAKE) |-> (phase_q == hss_pkg::PH_AWAKE) [*8])
		else $error("awake phase too short");
	a_conv_len: assert property (upd_edge |-> (chk_cyc_q == CHK_CONV))
		else $error("conversion not 14 ticks");
	a_update_sleep: assert property (upd_edge |=> phase_q == hss_pkg::PH_SLEEP)
		else $error("no sleep after update");
	a_pull_down: assert property (MODE_SELECT_PULL_DOWN)
		else $error("pull-down released");
	a_rise_start: assert property (pin_rise && idle && !tick |-> ##[1:100] start)
		else $error("pulse did not start sample");
	a_turbo_space: assert property (turbo_due |-> (chk_cyc_q == CHK_TURBO))
		else $error("turbo spacing wrong");
	a_done_pulse: assert property (SAMPLE_DONE |=> !SAMPLE_DONE)
		else $error("done not a pulse");

	c_ext_sample: cover property (tick && start && trig_pend_q);
	c_merge: cover property (pin_rise && !idle);
	c_turbo: cover property (turbo_due);
	c_micro: cover property (!pin_q && micro_due && start);

endmodule : hss_sequencer

// ==== testbench/hss_mcu_model.sv ====
/*
 * partner model: controller that drives the mode select pin.
 * assumes the sequencer clock; drives only after falling edges.
 */
module hss_mcu_model (
	// clock
	input  wire logic clk,
	// pin drive and its enable
	output logic      pin_level,
	output logic      pin_en
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int MIN_HIGH = 200;
	initial begin
		pin_level = 1'b0;
		pin_en    = 1'b0;
	end
	// =====================================================================
	// pin drive tasks
	// =====================================================================
	task automatic float_pin();
		@(negedge clk);
		pin_en = 1'b0;
	endtask : float_pin
	task automatic hold(input logic lvl);
		@(negedge clk);
		pin_en    = 1'b1;
		pin_level = lvl;
	endtask : hold
	task automatic pulse(input int high_cyc);
		int w;
		w = (high_cyc < MIN_HIGH) ? MIN_HIGH : high_cyc;
		hold(1'b1);
		repeat (w) @(negedge clk);
		pin_level = 1'b0;
	endtask : pulse
endmodule : hss_mcu_model

// ==== testbench/hall_sample_sequencer_tb_top.sv ====
/*
 * testbench top: sequencer, pin controller model, scenario tasks.
 * assumes a 10 MHz clock; the micropower period is shortened by parameter.
 */
module hall_sample_sequencer_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int MICRO = 20000;
	logic              clk, rst, pin_drv, pin_en, pull_dn, awake, turbo, done;
	logic signed [11:0] field;
	logic        [7:0]  code;
	wire               pin;
	int                error_cnt, checked, cyc;
	// floating pin settles to the pull-down level
	assign pin = pin_en ? pin_drv : ~pull_dn;
	hss_mcu_model u_mcu (.clk(clk), .pin_level(pin_drv), .pin_en(pin_en));
	hss_sequencer #(.MICRO_CYCLES(MICRO)) u_dut (
		.CLOCK(clk), .RESET(rst), .MODE_SELECT_PIN(pin), .MODE_SELECT_PULL_DOWN(pull_dn),
		.FIELD_SAMPLE(field), .AWAKE(awake), .TURBO_MODE(turbo), .SAMPLE_DONE(done),
		.OUTPUT_CODE(code));
	// =====================================================================
	// clock, cycle count, compares
	// =====================================================================
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) cyc <= cyc + 1;
	task automatic fail_line(input string what, input string exp, input string got);
		error_cnt++;
		$display("[FAIL] %s expected %s seen %s", what, exp, got);
	endtask : fail_line
	task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) fail_line(what, $sformatf("%h", exp), $sformatf("%h", got));
	endtask : cmp8
	task automatic cmp1(input string what, input logic exp, input logic got);
		checked++;
		if (got !== exp) fail_line(what, $sformatf("%b", exp), $sformatf("%b", got));
	endtask : cmp1
	task automatic cmp_rng(input string what, input int lo, input int hi, input int got);
		checked++;
		if (got < lo || got > hi) fail_line(what, $sformatf("%0d..%0d", lo, hi), $sformatf("%0d", got));
	endtask : cmp_rng
	task automatic wait_done(input int lim, output int at);
		int n;
		n = 0;
		@(negedge clk);
		while (done !== 1'b1 && n < lim) begin
			@(negedge clk);
			n++;
		end
		at = cyc;
		cmp_rng("done wait", 0, lim - 1, n);
	endtask : wait_done
	task automatic tally_and_finish();
		$display("errors %0d checks %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : tally_and_finish
	// =====================================================================
	// scenarios
	// =====================================================================
	task automatic t_reset();
		cmp8("reset code", 8'h80, code);
		cmp1("pull-down", 1'b1, pull_dn);
		cmp1("reset awake", 1'b0, awake);
	endtask : t_reset
	task automatic t_micro();
		int a, b;
		u_mcu.float_pin();
		wait_done(MICRO + 1800, a);
		wait_done(MICRO + 200, b);
		cmp_rng("micro interval", MICRO, MICRO + 100, b - a);
	endtask : t_micro
	task automatic t_turbo();
		int a, b;
		u_mcu.hold(1'b1);
		wait_done(1800, a);
		wait_done(1800, b);
		cmp_rng("turbo interval", 1600, 1600, b - a);
		cmp1("turbo flag", 1'b1, turbo);
		u_mcu.hold(1'b0);
		repeat (1700) @(negedge clk);
		cmp1("turbo flag low", 1'b0, turbo);
	endtask : t_turbo
	task automatic t_ext(input logic signed [11:0] f);
		int t0, ta, tf, td, n, extra;
		logic [7:0] c0;
		logic pa, held;
		@(negedge clk);
		field = f;
		c0 = code;
		pa = awake;
		held = 1'b1;
		{ta, tf, td, extra} = '0;
		t0 = cyc + 1;
		fork
			u_mcu.pulse(400);
			for (n = 0; n < 1700 && td == 0; n++) begin
				@(negedge clk);
				if (awake && !pa) ta = cyc;
				if (!awake && pa) tf = cyc;
				if (awake && code !== c0) held = 1'b0;
				if (done === 1'b1) td = cyc;
				pa = awake;
			end
		join
		// spacing to the next pulse stays above one conversion period
		repeat (300) @(negedge clk) if (done === 1'b1) extra++;
		cmp_rng("trigger delay", 101, 203, ta - t0);
		cmp_rng("awake span", 1200, 1200, tf - ta);
		cmp_rng("update time", 1299, 1299, td - ta);
		cmp1("code held", 1'b1, held);
		cmp8("field code", {~f[11], f[10:4]}, code);
		cmp_rng("extra samples", 0, 0, extra);
	endtask : t_ext
	task automatic t_merge();
		int n, cnt;
		cnt = 0;
		fork
			begin
				u_mcu.pulse(200);
				repeat (300) @(negedge clk);
				u_mcu.pulse(200);
			end
			for (n = 0; n < 3800; n++) @(negedge clk) if (done === 1'b1) cnt++;
		join
		cmp_rng("pending sample", 2, 2, cnt);
	endtask : t_merge
	// =====================================================================
	// main sequence and watchdog
	// =====================================================================
	initial begin
		logic signed [11:0] tab [7];
		tab = '{12'h000, 12'hFFF, 12'h001, 12'h7FF, 12'h800, 12'h123, 12'hEDD};
		{error_cnt, checked, cyc} = '0;
		rst = 1'b1;
		field = '0;
		repeat (10) @(negedge clk);
		rst = 1'b0;
		t_reset();
		t_micro();
		t_turbo();
		foreach (tab[i]) t_ext(tab[i]);
		t_merge();
		tally_and_finish();
	end
	initial begin
		repeat (90000) @(posedge clk);
		fail_line("watchdog", "finish", "timeout");
		tally_and_finish();
	end
endmodule : hall_sample_sequencer_tb_top
